// ### trs_link_reader.sv
// trs_link_reader: host model that pulls result bytes over the link read port.
// assumes the block answers one link edge after each start or advance.
`timescale 1ns/1ps
module trs_link_reader (
  input  wire logic       i_clk_link,
  input  wire logic [7:0] i_lk_rd_byte,
  input  wire logic       i_lk_byte_valid,
  output logic            o_lk_rd_start,
  output logic            o_lk_byte_adv
);
  initial begin
    o_lk_rd_start = 1'b0;
    o_lk_byte_adv = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // gap makes a slow host; ok is low if a handshake level was wrong
  task automatic pull(input int gap, input bit both, output logic [15:0] w, output logic ok);
    w = 16'h0000;
    @(posedge i_clk_link) o_lk_rd_start <= 1'b1;
    @(posedge i_clk_link) o_lk_rd_start <= 1'b0;
    @(posedge i_clk_link) w[15:8] = i_lk_rd_byte;
    ok = (i_lk_byte_valid === 1'b1);
    repeat (gap) @(posedge i_clk_link);
    // a host that needs no fine bits stops after the first byte
    if (both) begin
      o_lk_byte_adv <= 1'b1;
      @(posedge i_clk_link) o_lk_byte_adv <= 1'b0;
      @(posedge i_clk_link) w[7:0] = i_lk_rd_byte;
      ok = ok & (i_lk_byte_valid === 1'b1);
      o_lk_byte_adv <= 1'b1;
      @(posedge i_clk_link) o_lk_byte_adv <= 1'b0;
      @(posedge i_clk_link) ok = ok & (i_lk_byte_valid === 1'b0) & (i_lk_rd_byte === 8'h00);
    end
  endtask
endmodule // trs_link_reader

// ### trs_pkg.sv
// trs_pkg: constants shared by the temperature result register block.
// assumes a 100 MHz system clock and a byte-wide link-side read port.
package trs_pkg;

  // result word layout
  localparam int unsigned TRS_WORD_W       = 16;
  localparam int unsigned TRS_NORM_CODE_W  = 12;
  localparam int unsigned TRS_EXT_CODE_W   = 13;
  localparam int unsigned TRS_NORM_SHIFT   = 4;
  localparam int unsigned TRS_EXT_SHIFT    = 3;
  localparam int unsigned TRS_FLAG_POS     = 0;
  localparam logic [15:0] TRS_RESULT_RESET = 16'h0000;
  localparam logic [7:0]  TRS_BYTE_IDLE    = 8'h00;

  // conversion rate selection, codes 00..11
  localparam logic [1:0]  TRS_RATE_RESET   = 2'h2;
  localparam int unsigned TRS_SYS_CLK_NS   = 10;
  localparam int unsigned TRS_PERIOD_MS_0  = 4000;
  localparam int unsigned TRS_PERIOD_MS_1  = 1000;
  localparam int unsigned TRS_PERIOD_MS_2  = 250;
  localparam int unsigned TRS_PERIOD_MS_3  = 125;
  localparam int unsigned TRS_CYC_PER_MS   = 1000000 / TRS_SYS_CLK_NS;
  localparam int unsigned TRS_CONV_CYC_0   = TRS_PERIOD_MS_0 * TRS_CYC_PER_MS;
  localparam int unsigned TRS_CONV_CYC_1   = TRS_PERIOD_MS_1 * TRS_CYC_PER_MS;
  localparam int unsigned TRS_CONV_CYC_2   = TRS_PERIOD_MS_2 * TRS_CYC_PER_MS;
  localparam int unsigned TRS_CONV_CYC_3   = TRS_PERIOD_MS_3 * TRS_CYC_PER_MS;

  // link-side byte server
  typedef enum logic [1:0] {
    TRS_LK_IDLE,
    TRS_LK_MSB,
    TRS_LK_LSB
  } trs_lk_state_type;

endpackage

// ### trs_sync2.sv
// trs_sync2: two-flop synchroniser for a level from another clock domain.
// assumes the input is a level or a toggle that holds for several cycles.
`timescale 1ns/1ps
module trs_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // trs_sync2

// ### trs_temperature_result.sv
// trs_temperature_result: result register, formatter, rate timer and link byte server.
// assumes the converter reports a signed count on i_clk_sys and the link reader runs on i_clk_link.
//
// Summary of operation
// - each finished conversion overwrites the result register with the newest value
// - result register is read-only, 12-bit code normally, 13-bit code in extended range
// - result leaves as two bytes, most significant byte first, then least
// - code sits left-justified: top 12 bits normally, top 13 bits in extended range
// - one code step equals 0.0625 degrees Celsius
// - negative temperatures are two's-complement across the active code width
// - after reset the register reads zero degrees until the first conversion loads
// - bit 0 of the second byte mirrors the extended range flag
// - all bits outside code and format flag always read zero
// - rate select 00/01/10/11 gives 0.25/1/4/8 conversions per second, default 10
// - extended range covers up to 150 degrees, e.g. 0960 hex and 1C90 hex
// - code is temperature over step, left-justified, sign in the top code bit
`timescale 1ns/1ps
module trs_temperature_result
  import trs_pkg::*;
#(
  parameter int unsigned P_CONV_CYC_0 = TRS_CONV_CYC_0,
  parameter int unsigned P_CONV_CYC_1 = TRS_CONV_CYC_1,
  parameter int unsigned P_CONV_CYC_2 = TRS_CONV_CYC_2,
  parameter int unsigned P_CONV_CYC_3 = TRS_CONV_CYC_3
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_conv_rate_sel,
  input  wire logic        i_extended_range_flag,
  input  wire logic        i_conv_done,
  input  wire logic [12:0] i_conv_value,
  output logic             o_conv_start,
  input  wire logic        i_clk_link,
  input  wire logic        i_lk_rd_start,
  input  wire logic        i_lk_byte_adv,
  output logic [7:0]       o_lk_rd_byte,
  output logic             o_lk_byte_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // system domain: rate timer

  logic [1:0]  rate_q;
  logic [1:0]  rate_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic        start_q;
  logic        start_d;
  logic [31:0] period;

  always_comb begin
    rate_d  = i_conv_rate_sel;
    case (rate_q)
      2'h0:    period = P_CONV_CYC_0;
      2'h1:    period = P_CONV_CYC_1;
      2'h2:    period = P_CONV_CYC_2;
      default: period = P_CONV_CYC_3;
    endcase
    start_d = 1'b0;
    tmr_d   = tmr_q + 32'h00000001;
    // a changed rate restarts the interval so the new rate applies at once
    if (rate_d != rate_q) begin
      tmr_d = 32'h00000000;
    end else if (tmr_q >= period - 32'h00000001) begin
      tmr_d   = 32'h00000000;
      start_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rate_q  <= TRS_RATE_RESET;
      tmr_q   <= 32'h00000000;
      start_q <= 1'b0;
    end else begin
      rate_q  <= rate_d;
      tmr_q   <= tmr_d;
      start_q <= start_d;
    end
  end

  assign o_conv_start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: result register and formatter

  logic [15:0] result_q;
  logic [15:0] result_d;
  logic [15:0] fmt;
  logic [15:0] pub_q;
  logic [15:0] pub_d;
  logic        req_q;
  logic        req_d;
  logic        ack_sys;

  // the input count is already in 0.0625 degree steps, so no scaling here
  always_comb begin
    if (i_extended_range_flag) begin
      fmt = 16'(i_conv_value[TRS_EXT_CODE_W-1:0]) << TRS_EXT_SHIFT;
      fmt[TRS_FLAG_POS] = 1'b1;
    end else begin
      fmt = 16'(i_conv_value[TRS_NORM_CODE_W-1:0]) << TRS_NORM_SHIFT;
    end
    // only the converter writes; no bus write path exists
    result_d = i_conv_done ? fmt : result_q;
    // publish a new copy only once the link has taken the previous one
    pub_d = pub_q;
    req_d = req_q;
    if (req_q == ack_sys && pub_q != result_q) begin
      pub_d = result_q;
      req_d = ~req_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_q <= TRS_RESULT_RESET;
      pub_q    <= TRS_RESULT_RESET;
      req_q    <= 1'b0;
    end else begin
      result_q <= result_d;
      pub_q    <= pub_d;
      req_q    <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossing: toggle request and acknowledge, data held stable meanwhile

  logic req_lk;
  logic ack_q;
  logic ack_d;

  trs_sync2 #(.W(1)) u_req_sync (
    .i_clk   (i_clk_link),
    .i_rst_n (i_rst_n),
    .i_async (req_q),
    .o_sync  (req_lk)
  );

  trs_sync2 #(.W(1)) u_ack_sync (
    .i_clk   (i_clk_sys),
    .i_rst_n (i_rst_n),
    .i_async (ack_q),
    .o_sync  (ack_sys)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link domain: latest copy, read snapshot and byte server

  logic [15:0]      lk_word_q;
  logic [15:0]      lk_word_d;
  logic [15:0]      snap_q;
  logic [15:0]      snap_d;
  trs_lk_state_type st_q;
  trs_lk_state_type st_d;
  logic [7:0]       byte_q;
  logic [7:0]       byte_d;
  logic             valid_q;
  logic             valid_d;

  always_comb begin
    lk_word_d = lk_word_q;
    ack_d     = ack_q;
    if (req_lk != ack_q) begin
      lk_word_d = pub_q;
      ack_d     = req_lk;
    end
    snap_d  = snap_q;
    st_d    = st_q;
    byte_d  = byte_q;
    valid_d = valid_q;
    // a new start restarts from the high byte, so an early stop is harmless
    if (i_lk_rd_start) begin
      snap_d  = lk_word_q;
      st_d    = TRS_LK_MSB;
      byte_d  = lk_word_q[15:8];
      valid_d = 1'b1;
    end else if (i_lk_byte_adv) begin
      case (st_q)
        TRS_LK_MSB: begin
          st_d   = TRS_LK_LSB;
          byte_d = snap_q[7:0];
        end
        TRS_LK_LSB: begin
          st_d    = TRS_LK_IDLE;
          byte_d  = TRS_BYTE_IDLE;
          valid_d = 1'b0;
        end
        default: begin
          st_d    = TRS_LK_IDLE;
          byte_d  = TRS_BYTE_IDLE;
          valid_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_link or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_word_q <= TRS_RESULT_RESET;
      ack_q     <= 1'b0;
      snap_q    <= TRS_RESULT_RESET;
      st_q      <= TRS_LK_IDLE;
      byte_q    <= TRS_BYTE_IDLE;
      valid_q   <= 1'b0;
    end else begin
      lk_word_q <= lk_word_d;
      ack_q     <= ack_d;
      snap_q    <= snap_d;
      st_q      <= st_d;
      byte_q    <= byte_d;
      valid_q   <= valid_d;
    end
  end

  assign o_lk_rd_byte    = byte_q;
  assign o_lk_byte_valid = valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_load;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_conv_done && !i_extended_range_flag |=>
      result_q == {$past(i_conv_value[11:0]), 4'h0};
  endproperty
  a_load: assert property (p_load) else $error("result not loaded from conversion");

  property p_ext_load;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_conv_done && i_extended_range_flag |=>
      result_q == {$past(i_conv_value), 3'h1};
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("extended code misplaced");

  property p_flag;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_conv_done |=> result_q[0] == $past(i_extended_range_flag);
  endproperty
  a_flag: assert property (p_flag) else $error("format flag wrong");

  property p_zero_bits;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    result_q[0] ? (result_q[2:1] == 2'h0) : (result_q[3:1] == 3'h0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");

  property p_neg;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_conv_done && i_extended_range_flag && i_conv_value[12] |=> result_q[15];
  endproperty
  a_neg: assert property (p_neg) else $error("sign bit lost");

  property p_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_conv_done |=> $stable(result_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without conversion");

  property p_rate;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_conv_start |-> ($past(tmr_q) == period - 32'h00000001) ##1 !o_conv_start;
  endproperty
  a_rate: assert property (p_rate) else $error("conversion start off period");

  property p_msb_first;
    @(posedge i_clk_link) disable iff (!i_rst_n)
    i_lk_rd_start |=> o_lk_byte_valid && o_lk_rd_byte == snap_q[15:8] && st_q == TRS_LK_MSB;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first byte is not the high byte");

  property p_lsb;
    @(posedge i_clk_link) disable iff (!i_rst_n)
    st_q == TRS_LK_MSB && i_lk_byte_adv && !i_lk_rd_start |=>
      o_lk_rd_byte == snap_q[7:0] && $stable(snap_q);
  endproperty
  a_lsb: assert property (p_lsb) else $error("second byte not from same snapshot");

endmodule // trs_temperature_result

// ### trs_temperature_result_bench.sv
// trs_temperature_result_bench: self-checking bench for the result register.
// assumes trs_link_reader as link host; the bench plays the converter.
`timescale 1ns/1ps
module trs_temperature_result_bench;
  import trs_pkg::*;
  localparam int unsigned P0 = 40, P1 = 20, P2 = 10, P3 = 5;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0;
  logic [1:0]  rate_sel = 2'h2;
  logic        ext_flag = 1'b0, conv_done = 1'b0, conv_start;
  logic [12:0] conv_value = 13'h0000;
  logic        lk_rd_start, lk_byte_adv, lk_byte_valid;
  logic [7:0]  lk_rd_byte;
  int          fail_count = 0, total_checks = 0;
  always #5 clk_sys = ~clk_sys;
  always #24 clk_link = ~clk_link;
  trs_temperature_result #(.P_CONV_CYC_0(P0), .P_CONV_CYC_1(P1), .P_CONV_CYC_2(P2), .P_CONV_CYC_3(P3)) dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_conv_rate_sel(rate_sel),
    .i_extended_range_flag(ext_flag), .i_conv_done(conv_done), .i_conv_value(conv_value),
    .o_conv_start(conv_start), .i_clk_link(clk_link), .i_lk_rd_start(lk_rd_start),
    .i_lk_byte_adv(lk_byte_adv), .o_lk_rd_byte(lk_rd_byte), .o_lk_byte_valid(lk_byte_valid));
  trs_link_reader host (.i_clk_link(clk_link), .i_lk_rd_byte(lk_rd_byte), .i_lk_byte_valid(lk_byte_valid),
    .o_lk_rd_start(lk_rd_start), .o_lk_byte_adv(lk_byte_adv));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] exp);
    logic [15:0] w;
    logic        ok;
    host.pull(0, 1'b1, w, ok);
    chk(nm, w, exp);
    chk("handshake", {15'h0000, ok}, 16'h0001);
  endtask
  // 20 system cycles cover the crossing into the link domain
  task automatic convert(input logic [12:0] v, input logic f);
    @(posedge clk_sys);
    conv_value <= v;
    ext_flag <= f;
    conv_done <= 1'b1;
    @(posedge clk_sys) conv_done <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (conv_start !== 1'b1 && n < 100);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_rate;
    int per[4] = '{P0, P1, P2, P3};
    int n;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys) rate_sel <= c[1:0];
      gap(n);
      gap(n);
      gap(n);
      chk("rate period", n[15:0], per[c][15:0]);
    end
    $display("rate test done");
  endtask
  task automatic t_format;
    logic [12:0] tv[6] = '{13'h0190, 13'h1C90, 13'h0FFC, 13'h0960, 13'h1C90, 13'h1FFC};
    logic        tf[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [15:0] te[6] = '{16'h1900, 16'hC900, 16'hFFC0, 16'h4B01, 16'hE481, 16'hFFE1};
    for (int i = 0; i < 6; i++) begin
      convert(tv[i], tf[i]);
      rd_chk("format word", te[i]);
    end
    $display("format test done");
  endtask
  task automatic t_overwrite;
    logic [15:0] w;
    logic        ok;
    convert(13'h0004, 1'b0);
    convert(13'h0E70, 1'b0);
    host.pull(0, 1'b0, w, ok);
    chk("first byte only", w, 16'hE700);
    rd_chk("latest word", 16'hE700);
    $display("overwrite test done");
  endtask
  task automatic t_snapshot;
    logic [15:0] w;
    logic        ok;
    // low bytes differ so a low byte taken from the newer word is caught
    convert(13'h0324, 1'b0);
    fork
      host.pull(40, 1'b1, w, ok);
      begin
        repeat (30) @(posedge clk_sys);
        convert(13'h0501, 1'b0);
      end
    join
    chk("snapshot word", w, 16'h3240);
    rd_chk("after snapshot", 16'h5010);
    $display("snapshot test done");
  endtask
  task automatic t_reset_again;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (3) @(posedge clk_link);
    @(posedge clk_sys) rst_n <= 1'b1;
    rd_chk("reset again word", 16'h0000);
    $display("mid-run reset test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    // held in link cycles so both domains see at least two edges
    repeat (3) @(posedge clk_link);
    @(posedge clk_sys) rst_n <= 1'b1;
    rd_chk("reset word", 16'h0000);
    $display("reset test done");
    t_rate();
    t_format();
    t_overwrite();
    t_snapshot();
    t_reset_again();
    give_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule // trs_temperature_result_bench
